// file: hw/wdg_top.sv
// watchdog timer: lf time base, prescaler, modes, sleep handling, apb regs
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module wdg_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] watchdogModeSelect,
  input wire logic watchdogClearInstruction,
  input wire logic sleepActive,
  input wire logic oscFail,
  input wire logic oscillatorStartupTimer,
  input wire logic [3:0] internalOscFreqSelect,
  output logic resetReq,
  output logic wakeReq,
  output logic expiryStatusFlag,
  output logic sleepStatusFlag,
  output logic irq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } wdg_state_t;

  wdg_pkg::wdg_ctrl_t ctrl_r;
  wdg_pkg::wdg_flags_t flags_r;
  wdg_state_t state_r;
  wdg_state_t state_nxt;
  logic [wdg_pkg::PRESCALE_W-1:0] count_r;
  logic [wdg_pkg::IRQ_W-1:0] irqStat_r;
  logic [wdg_pkg::IRQ_W-1:0] irqEn_r;
  logic [wdg_pkg::IRQ_W-1:0] irqEvt;
  logic lfTick;
  logic sleepSync;
  logic sleepPrev_r;
  logic oscFailSync;
  logic ostSync;
  logic enabled;
  logic clearCond;
  logic expire;
  logic swClear;
  logic apbWrite;
  logic sleepEnter;
  logic sleepExit;
  logic [31:0] rdata;
  logic addrOk;

  // terminal count mask for a period code, reserved codes fall back to minimum
  function automatic logic [wdg_pkg::PRESCALE_W-1:0] ratioMask(input logic [4:0] code);
    logic [4:0] eff;
    eff = code;
    if (code > wdg_pkg::PERIOD_MAX) begin
      eff = 5'h00;
    end
    ratioMask = wdg_pkg::PRESCALE_W'((24'h000001 << (eff + 5'(wdg_pkg::MIN_RATIO_LOG2))) - 24'h000001);
  endfunction

  // write strobe for one register offset
  function automatic logic regWrite(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
    regWrite = wr && (addr == ofs);
  endfunction

  wdg_lf_tick uLfTick (
    .sys_clk(sys_clk),
    .rst(rst),
    .lfTick(lfTick)
  );

  wdg_sync uSyncSleep (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(sleepActive),
    .dout(sleepSync)
  );

  wdg_sync uSyncFail (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(oscFail),
    .dout(oscFailSync)
  );

  wdg_sync uSyncOst (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(oscillatorStartupTimer),
    .dout(ostSync)
  );

  assign apbWrite = psel && penable && pwrite;
  assign sleepEnter = sleepSync && !sleepPrev_r;
  assign sleepExit = !sleepSync && sleepPrev_r;
  assign swClear = watchdogClearInstruction
    || (regWrite(apbWrite, paddr, wdg_pkg::CLEAR_OFS) && pwdata[wdg_pkg::CLEAR_BIT]);

  // mode decode
  always_comb begin
    case (watchdogModeSelect)
      wdg_pkg::MODE_ON: enabled = 1'b1;
      wdg_pkg::MODE_NOSLEEP: enabled = !sleepSync;
      wdg_pkg::MODE_SOFT: enabled = ctrl_r.softEn;
      default: enabled = 1'b0;
    endcase
  end

  // upper mode bit means soft enable is never consulted above
  // clear sources; oscillator divider not among them
  assign clearCond = !enabled || swClear || oscFailSync || sleepEnter || sleepExit;
  assign expire = (state_r == ST_RUN) && lfTick && (count_r == ratioMask(ctrl_r.periodSel));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (enabled && ostSync) begin
          state_nxt = ST_HOLD;
        end else if (enabled) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enabled) begin
          state_nxt = ST_IDLE;
        end else if (ostSync) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!enabled) begin
          state_nxt = ST_IDLE;
        end else if (!ostSync) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      sleepPrev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sleepPrev_r <= sleepSync;
    end
  end

  // timeout only when no clear source is active
  logic hit;
  assign hit = expire && !clearCond;

  // count clear; sleep entry clear, restart if enabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= '0;
    end else if (clearCond || state_r != ST_RUN || hit) begin
      count_r <= '0;
    end else if (lfTick) begin
      count_r <= count_r + 1'b1;
    end
  end

  // awake reset; wake from sleep with flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resetReq <= 1'b0;
      wakeReq <= 1'b0;
      flags_r <= '{expiryFlag: 1'b1, sleepFlag: 1'b1};
    end else begin
      resetReq <= hit && !sleepSync;
      wakeReq <= hit && sleepSync;
      if (hit) begin
        flags_r.expiryFlag <= 1'b0;
        flags_r.sleepFlag <= !sleepSync;
      end else if (swClear) begin
        flags_r <= '{expiryFlag: 1'b1, sleepFlag: 1'b1};
      end else if (sleepEnter) begin
        flags_r <= '{expiryFlag: 1'b1, sleepFlag: 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      expiryStatusFlag <= 1'b1;
      sleepStatusFlag <= 1'b1;
    end else begin
      expiryStatusFlag <= flags_r.expiryFlag;
      sleepStatusFlag <= flags_r.sleepFlag;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= '{periodSel: wdg_pkg::PERIOD_RST, softEn: wdg_pkg::SOFT_EN_RST};
    end else if (regWrite(apbWrite, paddr, wdg_pkg::CTRL_OFS)) begin
      ctrl_r.periodSel <= pwdata[wdg_pkg::PERIOD_MSB:wdg_pkg::PERIOD_LSB];
      ctrl_r.softEn <= pwdata[wdg_pkg::SOFT_EN_BIT];
    end
  end

  assign irqEvt = {hit && sleepSync, hit && !sleepSync};

  // sticky events, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStat_r <= '0;
    end else if (regWrite(apbWrite, paddr, wdg_pkg::IRQ_CLR_OFS)) begin
      irqStat_r <= (irqStat_r & ~pwdata[wdg_pkg::IRQ_W-1:0]) | irqEvt;
    end else begin
      irqStat_r <= irqStat_r | irqEvt;
    end
  end

  // irq enable, same layout as status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqEn_r <= '0;
    end else if (regWrite(apbWrite, paddr, wdg_pkg::IRQ_EN_OFS)) begin
      irqEn_r <= pwdata[wdg_pkg::IRQ_W-1:0];
    end
  end

  // level irq while an enabled event is pending
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqEn_r);
    end
  end

  // read mux; write-only registers read zero
  always_comb begin
    rdata = 32'h00000000;
    addrOk = 1'b1;
    case (paddr)
      wdg_pkg::CTRL_OFS: rdata = {26'h0, ctrl_r.periodSel, ctrl_r.softEn};
      // status: state, enable, divider at default, flags
      wdg_pkg::STAT_OFS: rdata = {25'h0, state_r, enabled, internalOscFreqSelect == 4'h0,
        flags_r.sleepFlag, flags_r.expiryFlag};
      wdg_pkg::IRQ_STAT_OFS: rdata = {30'h0, irqStat_r};
      wdg_pkg::IRQ_EN_OFS: rdata = {30'h0, irqEn_r};
      wdg_pkg::IRQ_CLR_OFS: rdata = 32'h00000000;
      wdg_pkg::CLEAR_OFS: rdata = 32'h00000000;
      default: addrOk = 1'b0;
    endcase
  end

  // zero wait state slave
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata;
      end
    end
  end
endmodule

// file: pkg/wdg_pkg.sv
// package: watchdog register map, field layout, modes and timing constants
package wdg_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] CLEAR_OFS = 8'h14;
  // control field positions
  localparam int SOFT_EN_BIT = 0;
  localparam int PERIOD_LSB = 1;
  localparam int PERIOD_MSB = 5;
  localparam logic [4:0] PERIOD_RST = 5'h0B;
  localparam logic [4:0] PERIOD_MAX = 5'h12;
  localparam logic SOFT_EN_RST = 1'b0;
  // clear register key bit
  localparam int CLEAR_BIT = 0;
  // irq bit positions
  localparam int IRQ_RESET_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_W = 2;
  // mode select codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;
  // low frequency time base: 31 kHz from the 100 MHz system clock
  localparam int SYS_CLK_HZ = 100000000;
  localparam int LFOSC_HZ = 31000;
  localparam int LFOSC_DIV = SYS_CLK_HZ / LFOSC_HZ;
  localparam int LFDIV_W = 12;
  localparam int PRESCALE_W = 24;
  localparam int MIN_RATIO_LOG2 = 5;

  typedef struct packed {
    logic [4:0] periodSel;
    logic softEn;
  } wdg_ctrl_t;

  typedef struct packed {
    logic expiryFlag;
    logic sleepFlag;
  } wdg_flags_t;
endpackage

// file: hw/wdg_lf_tick.sv
// low frequency oscillator model: one-cycle tick at 31 kHz
`timescale 1ns/1ps
module wdg_lf_tick (
  input wire logic sys_clk,
  input wire logic rst,
  output logic lfTick
);
  logic [wdg_pkg::LFDIV_W-1:0] divCnt_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      divCnt_r <= '0;
      lfTick <= 1'b0;
    end else if (divCnt_r == wdg_pkg::LFDIV_W'(wdg_pkg::LFOSC_DIV - 1)) begin
      divCnt_r <= '0;
      lfTick <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 1'b1;
      lfTick <= 1'b0;
    end
  end
endmodule

// file: hw/wdg_sync.sv
// three-stage synchroniser with agreement filter for one level
`timescale 1ns/1ps
module wdg_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

// file: verif/wdg_core_model.sv
// core model: sleep entry and exit, clear instruction, reset requests
`timescale 1ns/1ps
module wdg_core_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] coreCmd,
  input wire logic resetReq,
  input wire logic wakeReq,
  output logic sleepActive,
  output logic watchdogClearInstruction,
  output logic [7:0] resetCount
);
  always_ff @(posedge sys_clk) begin
    if (rst || wakeReq || coreCmd[1]) begin
      sleepActive <= 1'b0;
    end else if (coreCmd[0]) begin
      sleepActive <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    watchdogClearInstruction <= !rst && coreCmd[2];
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resetCount <= 8'h00;
    end else if (resetReq) begin
      resetCount <= resetCount + 8'h01;
    end
  end
endmodule

// file: verif/wdg_chk.sv
// checker: apb timing and watchdog output relations
`timescale 1ns/1ps
module wdg_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] watchdogModeSelect,
  input wire logic sleepActive,
  input wire logic oscFail,
  input wire logic resetReq,
  input wire logic wakeReq,
  input wire logic expiryStatusFlag,
  input wire logic sleepStatusFlag,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence expire_s;
    resetReq || wakeReq;
  endsequence
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("no pready");
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready held");
  unmapped_err_a: assert property (setup_s ##0 (paddr > 8'h14) |=> pslverr)
    else $error("no pslverr");
  mapped_ok_a: assert property (setup_s ##0 (paddr <= 8'h14 && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("bad pslverr");
  pulse_once_a: assert property (expire_s |=> !resetReq && !wakeReq)
    else $error("long pulse");
  expiry_mark_a: assert property (expire_s |-> ##[0:2] !expiryStatusFlag)
    else $error("no expiry flag");
  sleep_mark_a: assert property ($rose(sleepActive) |-> ##[1:8] !sleepStatusFlag)
    else $error("no sleep flag");
  off_quiet_a: assert property ((watchdogModeSelect == 2'h0) [*3] |-> !(resetReq || wakeReq))
    else $error("timeout when off");
  osc_quiet_a: assert property (oscFail [*8] |-> !(resetReq || wakeReq))
    else $error("timeout in osc fail");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !pready && !irq && !(resetReq || wakeReq))
    else $error("outputs not reset");
endmodule
bind wdg_top wdg_chk chk (.sys_clk, .rst, .psel, .penable, .paddr, .pready, .pslverr, .watchdogModeSelect,
  .sleepActive, .oscFail, .resetReq, .wakeReq, .expiryStatusFlag, .sleepStatusFlag, .irq);

// file: verif/tb_wdg_top.sv
// testbench: registers, modes, sleep and timeout of the watchdog
`timescale 1ns/1ps
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin fails++; $display("mismatch %s %0h %0h", n, e, g); end end
module tb_wdg_top;
  logic sys_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, oscFail = 1'b0, oscillator_startup_timer = 1'b0, err;
  logic pready, pslverr, clrIns, sleepActive, resetReq, wakeReq, expF, slpF, irq;
  logic [7:0] paddr = 8'h00, resetCount;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [1:0] mode = 2'h0;
  logic [2:0] coreCmd = 3'h0;
  logic [3:0] oscSel = 4'h0;
  // mode, soft enable, sleep, expected enable
  logic [4:0] tRow [6] = '{5'h04, 5'h08, 5'h0D, 5'h11, 5'h12, 5'h1B};
  int fails = 0, nChecks = 0, n;
  wdg_top uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .watchdogModeSelect(mode), .watchdogClearInstruction(clrIns), .sleepActive, .oscFail,
    .oscillatorStartupTimer(oscillator_startup_timer), .internalOscFreqSelect(oscSel), .resetReq, .wakeReq,
    .expiryStatusFlag(expF), .sleepStatusFlag(slpF), .irq);
  wdg_core_model core (.sys_clk, .rst, .coreCmd, .resetReq, .wakeReq, .sleepActive,
    .watchdogClearInstruction(clrIns), .resetCount);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input int w);
    @(posedge sys_clk);
    coreCmd <= c;
    @(posedge sys_clk);
    coreCmd <= 3'h0;
    repeat (w) @(posedge sys_clk);
  endtask
  task automatic closeOut;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #1200000;
    fails++;
    closeOut;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, wdg_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h16, rdat)
    apb(1'b0, wdg_pkg::STAT_OFS, 32'h0);
    `CHK("flags", 2'h3, rdat[1:0])
    apb(1'b1, wdg_pkg::CTRL_OFS, 32'hFFFFFFFF);
    apb(1'b1, 8'h18, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b0, wdg_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl bits", 32'h3F, rdat)
    for (int i = 0; i < 6; i++) begin
      mode <= tRow[i][4:3];
      apb(1'b1, wdg_pkg::CTRL_OFS, {31'h0, tRow[i][2]});
      cmd({2'h0, tRow[i][1]}, 10);
      apb(1'b0, wdg_pkg::STAT_OFS, 32'h0);
      `CHK("enabled", tRow[i][0], rdat[3])
      if (tRow[i][1]) `CHK("sleep flag", 1'b0, slpF)
      cmd(3'h2, 10);
    end
    cmd(3'h4, 3);
    `CHK("flags", 2'h3, {expF, slpF})
    oscillator_startup_timer <= 1'b1;
    cmd(3'h1, 10);
    cmd(3'h2, 10);
    apb(1'b0, wdg_pkg::STAT_OFS, 32'h0);
    `CHK("ost hold", 3'h4, rdat[6:4])
    oscillator_startup_timer <= 1'b0;
    apb(1'b1, wdg_pkg::CLEAR_OFS, 32'h1);
    cmd(3'h0, 3);
    `CHK("clear reg", 1'b1, slpF)
    apb(1'b0, wdg_pkg::STAT_OFS, 32'h0);
    `CHK("ost done", 3'h2, rdat[6:4])
    mode <= 2'h3;
    apb(1'b1, wdg_pkg::IRQ_EN_OFS, 32'h0);
    apb(1'b1, wdg_pkg::CTRL_OFS, 32'h3E);
    oscFail <= 1'b1;
    repeat (20) @(posedge sys_clk);
    oscFail <= 1'b0;
    cmd(3'h1, 0);
    n = 0;
    while (wakeReq !== 1'b1 && n < 110000) begin
      @(posedge sys_clk);
      n++;
      if (n == 50000) oscSel <= 4'hA;
    end
    `CHK("wake span", 1'b1, n > 31 * wdg_pkg::LFOSC_DIV && n < 32 * wdg_pkg::LFOSC_DIV + 100)
    cmd(3'h0, 3);
    `CHK("awake", 1'b0, sleepActive)
    `CHK("no reset", 8'h00, resetCount)
    `CHK("expiry", 1'b0, expF)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, wdg_pkg::IRQ_STAT_OFS, 32'h0);
    `CHK("irq stat", 2'h2, rdat[1:0])
    apb(1'b1, wdg_pkg::IRQ_EN_OFS, 32'h2);
    cmd(3'h0, 2);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, wdg_pkg::IRQ_CLR_OFS, 32'h2);
    cmd(3'h0, 2);
    `CHK("irq off", 1'b0, irq)
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, wdg_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h16, rdat)
    `CHK("flags reset", 2'h3, {expF, slpF})
    closeOut;
  end
endmodule
